// [shared/timer_pkg.sv]
/*
 Constants, register map and carrier types for the dual prescaled timer.
 Assumes a byte-wide data-space bus from the core, on the core clock.
*/
package timer_pkg;

   // Number of timer instances and datapath widths.
   localparam int NUM_TIMERS = 2;
   localparam int COUNT_W    = 8;
   localparam int PRESC_W    = 7;
   localparam int DIV_SEL_W  = 3;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 8;

   // The prescaler input is the oscillator divided by this figure.
   localparam int OSC_DIV = 12;
   localparam int OSC_DIV_W = 4;
   localparam logic [OSC_DIV_W-1:0] OSC_DIV_LAST = OSC_DIV_W'(OSC_DIV - 1);
   localparam logic [OSC_DIV_W-1:0] OSC_DIV_RESET = 4'h0;

   // Data-space addresses, entry 0 for the first timer, entry 1 for the second.
   localparam logic [ADDR_W-1:0] ADDR_PRESC [NUM_TIMERS] = '{8'hd2, 8'hda};
   localparam logic [ADDR_W-1:0] ADDR_COUNT [NUM_TIMERS] = '{8'hd3, 8'hdb};
   localparam logic [ADDR_W-1:0] ADDR_CTRL  [NUM_TIMERS] = '{8'hd4, 8'hdc};

   // Bits that exist in each control register; the shared enable pair
   // exists only in the first one.
   localparam logic [DATA_W-1:0] CTRL_MASK [NUM_TIMERS] = '{8'hff, 8'hcf};

   // Values after reset.
   localparam logic [COUNT_W-1:0] COUNT_RESET = 8'hff;
   localparam logic [PRESC_W-1:0] PRESC_RESET = 7'h7f;
   localparam logic [DATA_W-1:0]  CTRL_RESET  = 8'h00;
   localparam logic [DATA_W-1:0]  READ_IDLE   = 8'h00;

   // Count value that turns into zero on the next decrement.
   localparam logic [COUNT_W-1:0] COUNT_LAST = 8'h01;
   localparam logic [DATA_W-1:0]  DATA_ZERO  = 8'h00;

   // Control and status register layout, bit 7 down to bit 0.
   typedef struct packed {
      logic                 zero_reached_flag;
      logic                 zero_irq_enable;
      logic                 shared_enable_clear_bit;
      logic                 shared_enable_set_bit;
      logic                 prescaler_run_init;
      logic [DIV_SEL_W-1:0] division_select;
   } ctrl_s;

   // One data-space access as offered by the core.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              wr;
      logic              rd;
      logic [DATA_W-1:0] wdata;
   } bus_req_s;

endpackage : timer_pkg

// [rtl/timer_prescaler.sv]
/*
 Seven-bit down-counting prescaler with a selectable tap that yields the
 counter's decrement pulse. Assumes tick_in is a one-cycle pulse on the same
 clock and that the parent decides when a load is allowed.
*/
`timescale 1ns/10ps
module timer_prescaler #(
   parameter int WIDTH = timer_pkg::PRESC_W,
   parameter int SEL_W = timer_pkg::DIV_SEL_W
) (
   input  wire logic             ref_clk_in,
   input  wire logic             reset_n_in,
   input  wire logic             tick_in,
   input  wire logic             enable_in,
   input  wire logic             run_init_in,
   input  wire logic             load_in,
   input  wire logic [WIDTH-1:0] load_value_in,
   input  wire logic [SEL_W-1:0] div_sel_in,
   output logic      [WIDTH-1:0] value_out,
   output logic                  count_pulse_out
);

   logic [WIDTH-1:0] value_reg;
   logic [WIDTH-1:0] dec_value;
   logic [WIDTH:0]   taps;
   logic             step;
   logic             pulse_reg;

   assign dec_value = WIDTH'(value_reg - 1'b1);
   assign step      = tick_in && enable_in && run_init_in && !load_in;

   // Tap 0 is the prescaler input clock itself; tap k+1 is a rising edge
   // of prescaler bit k, seen as a 0 to 1 change on the decrement.
   assign taps[0] = 1'b1;
   genvar k;
   generate
      for (k = 0; k < WIDTH; k++) begin : g_tap
         assign taps[k+1] = !value_reg[k] && dec_value[k];
      end
   endgenerate

   // Prescaler state; the run bit low forces all ones and holds it there.
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         value_reg <= timer_pkg::PRESC_RESET;
      end else if (!run_init_in) begin
         value_reg <= timer_pkg::PRESC_RESET;
      end else if (load_in) begin
         value_reg <= load_value_in;
      end else if (step) begin
         value_reg <= dec_value;
      end
   end

   // The pulse is registered, so the counter follows its tap one cycle late,
   // which keeps the tap mux out of the counter's timing path.
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         pulse_reg <= 1'b0;
      end else begin
         pulse_reg <= step && taps[div_sel_in];
      end
   end

   assign value_out       = value_reg;
   assign count_pulse_out = pulse_reg;

endmodule : timer_prescaler

// [rtl/dual_prescaled_down_timer.sv]
/*
 Two identical prescaled down-counting timers with their data-space
 registers, interrupt requests and wake request.
 Assumes the core drives the data-space bus on ref_clk_in, one access per
 cycle, and that the core's interrupt logic reads the request levels.
*/
// How it works
// - Two timers, each an 8-bit down counter behind a 7-bit prescaler.
// - Counters sit at D3H and DBH, readable and writable.
// - Prescaler states read at D2H and DAH.
// - Control and status registers sit at D4H and DCH.
// - Counter steps down once per tap pulse; software loads and reads anytime.
// - Reaching zero by decrement sets the zero flag.
// - Flag and enable both high raise request, vector 3 or vector 1.
// - Any timer request also raises the wake request for WAIT.
// - Prescaler steps down on the oscillator divided by twelve.
// - Tap 0 is prescaler input; taps 1 to 7 are bit rising edges.
// - Run bit low forces prescaler to all ones and holds the counter.
// - With run bit high, a prescaler write loads 0 to 7FH.
// - Both timers run only with first control bit 4 high, bit 5 low.
// - Second control register lacks the shared enable bits.
// - Division select picks a factor of two to its value.
// - Writing 00H to counter or one to bit 7 sets the flag.
// - Reset gives counter FFH, prescaler 7FH, control cleared.
// - A counter write beats a simultaneous decrement to zero.
`timescale 1ns/10ps
module dual_prescaled_down_timer #(
   parameter int NUM_TIMERS = timer_pkg::NUM_TIMERS
) (
   input  wire logic                        ref_clk_in,
   input  wire logic                        reset_n_in,
   input  wire logic [timer_pkg::ADDR_W-1:0] bus_addr_in,
   input  wire logic                        bus_wr_in,
   input  wire logic                        bus_rd_in,
   input  wire logic [timer_pkg::DATA_W-1:0] bus_wdata_in,
   output logic      [timer_pkg::DATA_W-1:0] bus_rdata_out,
   output logic                             irq_timer1_out,
   output logic                             irq_timer2_out,
   output logic                             wake_out
);

   timer_pkg::bus_req_s req;

   logic [timer_pkg::OSC_DIV_W-1:0] div_cnt_reg;
   logic                            tick_reg;

   logic [timer_pkg::COUNT_W-1:0] count_q   [NUM_TIMERS];
   logic [timer_pkg::PRESC_W-1:0] presc_q   [NUM_TIMERS];
   timer_pkg::ctrl_s              ctrl_q    [NUM_TIMERS];
   logic [NUM_TIMERS-1:0]         irq_level;

   logic                          shared_enable;
   logic [timer_pkg::DATA_W-1:0]  rdata_next;
   logic [timer_pkg::DATA_W-1:0]  rdata_reg;
   logic [NUM_TIMERS-1:0]         irq_reg;
   logic                          wake_reg;

   // The core's access travels as one bundle from here on.
   assign req.addr  = bus_addr_in;
   assign req.wr    = bus_wr_in;
   assign req.rd    = bus_rd_in;
   assign req.wdata = bus_wdata_in;

   // Divide the oscillator by twelve into a one-cycle tick shared by both
   // prescalers. It runs free, so two timers started together stay aligned.
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         div_cnt_reg <= timer_pkg::OSC_DIV_RESET;
      end else if (div_cnt_reg == timer_pkg::OSC_DIV_LAST) begin
         div_cnt_reg <= timer_pkg::OSC_DIV_RESET;
      end else begin
         div_cnt_reg <= div_count_inc(div_cnt_reg);
      end
   end

   // Tick marks the first oscillator cycle of each group of twelve, when the divider is back at zero.
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= (div_cnt_reg == timer_pkg::OSC_DIV_LAST);
      end
   end

   // Increment helper sized to the divider so no bits are silently lost.
   function automatic logic [timer_pkg::OSC_DIV_W-1:0] div_count_inc(
      input logic [timer_pkg::OSC_DIV_W-1:0] value
   );
      div_count_inc = timer_pkg::OSC_DIV_W'(value + 1'b1);
   endfunction : div_count_inc

   // Only the first control register holds the shared enable pair, and
   // any pattern other than set-high, clear-low stops both timers.
   assign shared_enable = ctrl_q[0].shared_enable_set_bit &&
                          !ctrl_q[0].shared_enable_clear_bit;

   genvar i;
   generate
      for (i = 0; i < NUM_TIMERS; i++) begin : g_timer
         logic                          sel_presc;
         logic                          sel_count;
         logic                          sel_ctrl;
         logic                          count_pulse;
         logic                          count_step;
         logic                          zero_event;
         logic                          flag_set;
         logic [timer_pkg::COUNT_W-1:0] count_reg;
         timer_pkg::ctrl_s              ctrl_reg;
         timer_pkg::ctrl_s              ctrl_wr;

         // Address decode for this timer's three registers.
         assign sel_presc = req.wr && (req.addr == timer_pkg::ADDR_PRESC[i]);
         assign sel_count = req.wr && (req.addr == timer_pkg::ADDR_COUNT[i]);
         assign sel_ctrl  = req.wr && (req.addr == timer_pkg::ADDR_CTRL[i]);

         // Unimplemented control bits are dropped at the write.
         assign ctrl_wr = timer_pkg::ctrl_s'(req.wdata &
                                             timer_pkg::CTRL_MASK[i]);

         timer_prescaler #(
            .WIDTH (timer_pkg::PRESC_W),
            .SEL_W (timer_pkg::DIV_SEL_W)
         ) u_prescaler (
            .ref_clk_in      (ref_clk_in),
            .reset_n_in      (reset_n_in),
            .tick_in         (tick_reg),
            .enable_in       (shared_enable),
            .run_init_in     (ctrl_reg.prescaler_run_init),
            .load_in         (sel_presc && ctrl_reg.prescaler_run_init),
            .load_value_in   (req.wdata[timer_pkg::PRESC_W-1:0]),
            .div_sel_in      (ctrl_reg.division_select),
            .value_out       (presc_q[i]),
            .count_pulse_out (count_pulse)
         );

         // A pulse is honoured only while the timer may still run, so a
         // pulse already in flight when software stops the timer is lost.
         assign count_step = count_pulse && shared_enable &&
                             ctrl_reg.prescaler_run_init;

         // Decrement to zero counts only when no counter write competes.
         assign zero_event = count_step && !sel_count &&
                             (count_reg == timer_pkg::COUNT_LAST);

         // Software may also raise the flag on purpose.
         assign flag_set = zero_event ||
                           (sel_count && req.wdata == timer_pkg::DATA_ZERO);

         // Counter: a write always wins; otherwise step down and wrap.
         always_ff @(posedge ref_clk_in) begin
            if (!reset_n_in) begin
               count_reg <= timer_pkg::COUNT_RESET;
            end else if (sel_count) begin
               count_reg <= req.wdata;
            end else if (count_step) begin
               count_reg <= timer_pkg::COUNT_W'(count_reg - 1'b1);
            end
         end

         // Control and status. Writing bit 7 low clears the flag, but a
         // hardware set in the same cycle still wins over that clear.
         always_ff @(posedge ref_clk_in) begin
            if (!reset_n_in) begin
               ctrl_reg <= timer_pkg::ctrl_s'(timer_pkg::CTRL_RESET);
            end else if (sel_ctrl) begin
               ctrl_reg                   <= ctrl_wr;
               ctrl_reg.zero_reached_flag <= ctrl_wr.zero_reached_flag ||
                                             flag_set;
            end else if (flag_set) begin
               ctrl_reg.zero_reached_flag <= 1'b1;
            end
         end

         // The request is a level that lasts until software clears the
         // flag or the enable, so a late service loses nothing.
         assign irq_level[i] = ctrl_reg.zero_reached_flag &&
                               ctrl_reg.zero_irq_enable;

         assign count_q[i] = count_reg;
         assign ctrl_q[i]  = ctrl_reg;
      end
   endgenerate

   // Read mux; unmapped addresses answer zero. Values are live, so a read
   // shows the counter exactly as it stands in that cycle.
   always_comb begin
      rdata_next = timer_pkg::READ_IDLE;
      for (int n = 0; n < NUM_TIMERS; n++) begin
         if (req.addr == timer_pkg::ADDR_PRESC[n]) begin
            rdata_next = {1'b0, presc_q[n]};
         end
         if (req.addr == timer_pkg::ADDR_COUNT[n]) begin
            rdata_next = count_q[n];
         end
         if (req.addr == timer_pkg::ADDR_CTRL[n]) begin
            rdata_next = ctrl_q[n] & timer_pkg::CTRL_MASK[n];
         end
      end
   end

   // Read data is captured on a read strobe and held until the next one.
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         rdata_reg <= timer_pkg::READ_IDLE;
      end else if (req.rd) begin
         rdata_reg <= rdata_next;
      end
   end

   // Request levels are registered so the core sees clean outputs.
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         irq_reg <= '0;
      end else begin
         irq_reg <= irq_level;
      end
   end

   // Wake follows any timer request in the same cycle as the request
   // outputs; the oscillator keeps running in WAIT, so no delay is needed.
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         wake_reg <= 1'b0;
      end else begin
         wake_reg <= |irq_level;
      end
   end

   // Vector 3 belongs to the first timer, vector 1 to the second.
   assign bus_rdata_out  = rdata_reg;
   assign irq_timer1_out = irq_reg[0];
   assign irq_timer2_out = irq_reg[1];
   assign wake_out       = wake_reg;

endmodule : dual_prescaled_down_timer

// [sim/dual_prescaled_down_timer_props.sv]
/*
 Port checker for the dual prescaled down timer.
 Assumes it is bound onto the top module and shares its single clock.
*/
`timescale 1ns/10ps
module dual_prescaled_down_timer_props #(
   parameter int NUM_TIMERS = 2
) (
   input wire logic       ref_clk_in,
   input wire logic       reset_n_in,
   input wire logic [7:0] bus_addr_in,
   input wire logic       bus_wr_in,
   input wire logic       bus_rd_in,
   input wire logic [7:0] bus_wdata_in,
   input wire logic [7:0] bus_rdata_out,
   input wire logic       irq_timer1_out,
   input wire logic       irq_timer2_out,
   input wire logic       wake_out
);
   // One clock domain, so clock and reset are stated once.
   default clocking main_cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!reset_n_in);

   // A control write that sets both the flag and the enable of a timer.
   sequence set1_s;
      bus_wr_in && bus_addr_in == 8'hd4 && bus_wdata_in[7:6] == 2'b11;
   endsequence
   sequence set2_s;
      bus_wr_in && bus_addr_in == 8'hdc && bus_wdata_in[7:6] == 2'b11;
   endsequence
   sequence unmapped_rd_s;
      bus_rd_in && !(bus_addr_in inside {8'hd2, 8'hd3, 8'hd4, 8'hda, 8'hdb, 8'hdc});
   endsequence

   wake_or_a: assert property (wake_out == (irq_timer1_out | irq_timer2_out))
      else $error("wake differs from the request OR");
   irq1_raise_a: assert property (set1_s |-> ##2 irq_timer1_out)
      else $error("first request did not rise");
   irq2_raise_a: assert property (set2_s |-> ##2 irq_timer2_out)
      else $error("second request did not rise");
   irq1_drop_a: assert property (bus_wr_in && bus_addr_in == 8'hd4 && !bus_wdata_in[6]
      |-> ##2 !irq_timer1_out) else $error("first request stayed up");
   unmapped_read_a: assert property (unmapped_rd_s |=> bus_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   presc_msb_a: assert property (bus_rd_in && bus_addr_in inside {8'hd2, 8'hda}
      |=> !bus_rdata_out[7]) else $error("prescaler top bit set");
   ctrl2_hole_a: assert property (bus_rd_in && bus_addr_in == 8'hdc
      |=> bus_rdata_out[5:4] == 2'b00) else $error("second control shows enable pair");
   rdata_hold_a: assert property (!bus_rd_in |=> $stable(bus_rdata_out))
      else $error("read data moved without a read");
   reset_quiet_a: assert property ($rose(reset_n_in)
      |-> !irq_timer1_out && !irq_timer2_out && bus_rdata_out == 8'h00)
      else $error("outputs not clear after reset");
endmodule : dual_prescaled_down_timer_props

// [sim/dual_prescaled_down_timer_bench.sv]
/*
 Self-checking bench for the dual prescaled down timer.
 Assumes the design and its checker file are compiled beforehand.
*/
`timescale 1ns/10ps
module dual_prescaled_down_timer_bench;
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] expv;
   } row_s;
   logic       ref_clk_in;
   logic       reset_n_in;
   logic [7:0] bus_addr_in;
   logic       bus_wr_in;
   logic       bus_rd_in;
   logic [7:0] bus_wdata_in;
   logic [7:0] bus_rdata_out;
   logic       irq_timer1_out;
   logic       irq_timer2_out;
   logic       wake_out;
   logic [7:0] v;
   logic [7:0] stops [3] = '{8'h38, 8'h08, 8'h10};
   int         failures = 0;
   int         checks = 0;
   int         cycles = 0;
   int         g;
   // Reset values first, then write and read-back pairs and a final control read, in a chosen order.
   row_s rows [18] = '{
      '{1'b0, 8'hd2, 8'h00, 8'h7f}, '{1'b0, 8'hd3, 8'h00, 8'hff}, '{1'b0, 8'hd4, 8'h00, 8'h00},
      '{1'b0, 8'hda, 8'h00, 8'h7f}, '{1'b0, 8'hdb, 8'h00, 8'hff}, '{1'b0, 8'hdc, 8'h00, 8'h00},
      '{1'b1, 8'hd3, 8'h5a, 8'h5a}, '{1'b1, 8'hdb, 8'ha5, 8'ha5}, '{1'b1, 8'hd2, 8'h12, 8'h7f},
      '{1'b1, 8'he0, 8'h55, 8'h00}, '{1'b1, 8'hdc, 8'h7f, 8'h4f}, '{1'b1, 8'hdc, 8'hc0, 8'hc0},
      '{1'b1, 8'hdc, 8'h00, 8'h00}, '{1'b1, 8'hd4, 8'h08, 8'h08}, '{1'b1, 8'hd2, 8'h2a, 8'h2a},
      '{1'b1, 8'hd2, 8'hff, 8'h7f}, '{1'b1, 8'hd3, 8'h00, 8'h00}, '{1'b0, 8'hd4, 8'h00, 8'h88}};

   dual_prescaled_down_timer dut_u (
      .ref_clk_in    (ref_clk_in),
      .reset_n_in    (reset_n_in),
      .bus_addr_in   (bus_addr_in),
      .bus_wr_in     (bus_wr_in),
      .bus_rd_in     (bus_rd_in),
      .bus_wdata_in  (bus_wdata_in),
      .bus_rdata_out (bus_rdata_out),
      .irq_timer1_out(irq_timer1_out),
      .irq_timer2_out(irq_timer2_out),
      .wake_out      (wake_out)
   );

   // Free-running 10 MHz clock.
   initial begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end

   // Cuts a hang short; the ceiling is about two and three quarter times the expected run.
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         end_sim();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      checks++;
      if (seen !== expv) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask : check

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask : idle

   // A spare cycle after each access keeps strobes from being set twice in one step.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus_addr_in = a;
      bus_wdata_in = d;
      bus_wr_in = 1'b1;
      idle(1);
      bus_wr_in = 1'b0;
      idle(1);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      bus_addr_in = a;
      bus_rd_in = 1'b1;
      idle(1);
      bus_rd_in = 1'b0;
      d = bus_rdata_out;
      idle(1);
   endtask : rd

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      rd(a, v);
      check({8'h00, v}, {8'h00, e});
   endtask : rchk

   task automatic run_rows(input int lo, input int hi);
      for (int i = lo; i <= hi; i++) begin
         if (rows[i].wr) begin
            wr(rows[i].addr, rows[i].wdata);
         end
         rd(rows[i].addr, v);
         check({8'h00, v}, {8'h00, rows[i].expv});
      end
   endtask : run_rows

   // Needs a read strobe held high; returns once the streamed count changes.
   task automatic gap_wait(output int n);
      logic [7:0] p;
      p = bus_rdata_out;
      n = 0;
      while (bus_rdata_out === p && n < 2000) begin
         idle(1);
         n++;
      end
   endtask : gap_wait

   task automatic end_sim();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim

   // Main sequence: map, zero event, flag writes, stops, taps, collision, reset.
   initial begin
      reset_n_in = 1'b0;
      bus_addr_in = 8'h00;
      bus_wr_in = 1'b0;
      bus_rd_in = 1'b0;
      bus_wdata_in = 8'h00;
      idle(5);
      reset_n_in = 1'b1;
      check({13'h0, irq_timer1_out, irq_timer2_out, wake_out}, 16'h0);
      run_rows(0, 17);
      $display("test done: register map");
      wr(8'hd3, 8'h02);
      wr(8'hd4, 8'h58);
      for (g = 0; g < 80 && irq_timer1_out !== 1'b1; g++) begin
         idle(1);
      end
      check({14'h0, irq_timer1_out, wake_out}, 16'h3);
      check({15'h0, irq_timer2_out}, 16'h0);
      rchk(8'hd3, 8'h00);
      rchk(8'hd4, 8'hd8);
      idle(8);
      rchk(8'hd3, 8'hff);
      $display("test done: zero event");
      wr(8'hd4, 8'h18);
      check({15'h0, irq_timer1_out}, 16'h0);
      wr(8'hd4, 8'hd8);
      check({15'h0, irq_timer1_out}, 16'h1);
      wr(8'hd4, 8'h58);
      wr(8'hd3, 8'h00);
      check({15'h0, irq_timer1_out}, 16'h1);
      $display("test done: flag writes");
      for (int i = 0; i < 3; i++) begin
         wr(8'hd4, stops[i]);
         rd(8'hd3, v);
         idle(40);
         rchk(8'hd3, v);
      end
      rchk(8'hd2, 8'h7f);
      $display("test done: stops");
      for (int s = 0; s < 8; s++) begin
         wr(8'hd4, 8'h18 | 8'(s));
         bus_addr_in = 8'hd3;
         bus_rd_in = 1'b1;
         repeat (4) gap_wait(g);
         check(16'(g), 16'(12 << s));
         bus_rd_in = 1'b0;
      end
      $display("test done: taps");
      wr(8'hd4, 8'h18);
      bus_addr_in = 8'hd3;
      bus_rd_in = 1'b1;
      repeat (2) gap_wait(g);
      // The next decrement lands eleven edges on; the second write meets it.
      bus_wdata_in = 8'h01;
      bus_wr_in = 1'b1;
      idle(1);
      bus_wr_in = 1'b0;
      idle(9);
      bus_wdata_in = 8'h40;
      bus_wr_in = 1'b1;
      idle(1);
      bus_wr_in = 1'b0;
      rchk(8'hd4, 8'h18);
      rchk(8'hd3, 8'h40);
      $display("test done: collision");
      reset_n_in = 1'b0;
      idle(2);
      reset_n_in = 1'b1;
      run_rows(0, 5);
      $display("test done: second reset");
      end_sim();
   end
endmodule : dual_prescaled_down_timer_bench

bind dual_prescaled_down_timer dual_prescaled_down_timer_props #(
   .NUM_TIMERS(NUM_TIMERS)
) chk_u (
   .ref_clk_in    (ref_clk_in),
   .reset_n_in    (reset_n_in),
   .bus_addr_in   (bus_addr_in),
   .bus_wr_in     (bus_wr_in),
   .bus_rd_in     (bus_rd_in),
   .bus_wdata_in  (bus_wdata_in),
   .bus_rdata_out (bus_rdata_out),
   .irq_timer1_out(irq_timer1_out),
   .irq_timer2_out(irq_timer2_out),
   .wake_out      (wake_out)
);
